// ---- inc/tpw_pkg.sv ----
// Constants, register map and carrier types for the two-channel PWM timer.
// Assumes a 10 MHz core clock and a classic Wishbone slave with 32-bit data.
// Functional notes
// (RULE1) Toggle-on-overflow toggles pin at modulo reach
// (RULE2) Pulse width runs overflow to compare match
// (RULE3) Modulo 00ff, divide-by-one gives 256 clocks
// (RULE4) Compare 0080 at 8-bit period gives 50%
// (RULE5) Buffered bit links channels onto channel 0
// (RULE6) Last written pair takes control at overflow
// (RULE7) Linked mode ignores channel 1 control, frees pin
// (RULE8) Software writes only the inactive pair
// (RULE9) Compare/overflow flags pace unbuffered width updates
// (RULE10) Software follows the stop-configure-start sequence
// (RULE11) Edge/level 10 clears, 11 sets on compare
// (RULE12) Software avoids toggle on compare for PWM
// (RULE13) Toggle-on-overflow clear yields 0% duty
// (RULE14) Max duty with toggle-on-overflow gives 100%
// (RULE15) Overflow sets flag; enable gates interrupt
// (RULE16) Capture or compare sets channel flag, enable gates
// (RULE17) Wait mode runs timer, blocks access, wakes
// (RULE18) Stop mode halts timer, keeps all state; the code still takes bus writes and pin captures in stop mode
// (RULE19) Break freezes the counter
// (RULE20) Break blocks flag clears unless clear enabled
// (RULE21) Each pin capture or compare; buffering channel 0
// (RULE22) Prescaler divides by 1..64, code 111 off
// (RULE23) Counter reset clears count and prescaler, self-clears
// (RULE24) Overflow restarts count from zero next tick
// (RULE25) Flag clears by read-then-write-zero; set wins
// (RULE26) Interrupt lines hold until flag cleared
package tpw_pkg;

   localparam int           CORE_CLK_HZ   = 10_000_000;

   // Word addresses (byte address of each 32-bit register)
   localparam logic [7:0]   ADDR_TSC      = 8'h00;
   localparam logic [7:0]   ADDR_COUNT    = 8'h04;
   localparam logic [7:0]   ADDR_MODULO   = 8'h08;
   localparam logic [7:0]   ADDR_CH0_SC   = 8'h0c;
   localparam logic [7:0]   ADDR_CH0_VAL  = 8'h10;
   localparam logic [7:0]   ADDR_CH1_SC   = 8'h14;
   localparam logic [7:0]   ADDR_CH1_VAL  = 8'h18;

   localparam logic [15:0]  MODULO_RESET  = 16'hffff;
   localparam logic [15:0]  COUNT_RESET   = 16'h0000;
   localparam int           TRST_BIT      = 4;
   localparam int           FLAG_BIT      = 7;
   localparam logic [2:0]   PS_OFF        = 3'h7;

   // Edge/level actions on compare; for capture: rise, fall, any
   localparam logic [1:0]   ELS_NONE      = 2'h0;
   localparam logic [1:0]   ELS_TOGGLE    = 2'h1;
   localparam logic [1:0]   ELS_CLEAR     = 2'h2;
   localparam logic [1:0]   ELS_SET       = 2'h3;

   typedef struct packed {
      logic       flag;
      logic       irqEnable;
      logic       stop;
      logic       trst;
      logic       spare;
      logic [2:0] prescaleSelect;
   } tpw_tsc_t;

   localparam tpw_tsc_t     TSC_RESET     = '{stop: 1'b1, default: '0};

   typedef struct packed {
      logic       flag;
      logic       irqEnable;
      logic       modeB;
      logic       modeA;
      logic [1:0] edgeLevel;
      logic       toggleOnOverflow;
      logic       maxDuty;
   } tpw_chsc_t;

   typedef struct packed {
      logic [1:0] level;
      logic [1:0] driveN;
   } tpw_pins_t;

   typedef struct packed {
      logic       overflow;
      logic [1:0] channel;
      logic       wake;
   } tpw_irq_t;

   typedef struct packed {
      tpw_tsc_t               timer_status_control;
      logic [15:0]            count;
      logic [15:0]            modulo;
      tpw_chsc_t [1:0]        chsc;
      logic [1:0][15:0]       value;
      logic                   ovfArm;
      logic [1:0]             chArm;
      logic                   activeSel;
      logic                   lastWritten;
      logic                   pendSwap;
      logic [1:0][2:0]        pinSync;
      logic [1:0]             pinSeen;
      tpw_pins_t              pins;
      tpw_irq_t               irq;
      logic                   ack;
      logic [31:0]            rdat;
   } tpw_state_t;

endpackage : tpw_pkg

// ---- testbench/test_tpw_timer.sv ----
// Self-checking bench for the PWM timer over classic Wishbone.
// Assumes a 10 MHz core clock; all expectations follow from the register map.
`timescale 1ns/1ps
module test_tpw_timer;
   import tpw_pkg::*;
   logic        core_clk, reset_n, wbCycI, wbStbI, wbWeI;
   logic [7:0]  wbAdrI;
   logic [3:0]  wbSelI;
   logic [31:0] wbDatI, wbDatO, rd, a, b, hi, per;
   logic        wbAckO, waitMode, stopMode, breakActive;
   logic [1:0]  pinWire;
   tpw_pins_t   chanPins;
   tpw_irq_t    irqOut;
   int          errors, compares, n;

   tpw_timer dut_u (.core_clk(core_clk), .reset_n(reset_n), .wbCycI(wbCycI),
      .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
      .wbDatO(wbDatO), .wbAckO(wbAckO), .waitMode(waitMode), .stopMode(stopMode),
      .breakActive(breakActive), .breakClearEnable(1'b0), .chanPinIn(pinWire),
      .chanPins(chanPins), .irqOut(irqOut));
   tpw_pin_load load_u (.gpioLevel(2'h2), .chanPins(chanPins), .pinWire(pinWire));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic results();
      $display("Comparisons %0d, errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   task automatic bail(input int cnt, input int lim);
      if (cnt >= lim) begin
         errors++;
         results();
      end
   endtask : bail

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One classic cycle; read data is taken at the ack edge, before it can change
   task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
      int k;
      k = 0;
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      wbWeI  <= we;
      wbSelI <= 4'hf;
      wbAdrI <= ad;
      wbDatI <= d;
      do begin
         @(posedge core_clk);
         k++;
      end while (wbAckO !== 1'b1 && k < 50);
      q = wbDatO;
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
      wbWeI  <= 1'b0;
      wbSelI <= 4'h0;
      @(posedge core_clk);
      bail(k, 50);
   endtask : wb

   // Stop and clear first, then period, width, mode, start; never toggle on compare
   task automatic cfg(input logic [7:0] sc, input logic [15:0] v, input logic [2:0] ps);
      wb(1'b1, ADDR_TSC, 32'h30, rd);
      wb(1'b1, ADDR_MODULO, 32'hff, rd);
      wb(1'b1, ADDR_CH0_VAL, {16'h0, v}, rd);
      wb(1'b1, ADDR_CH0_SC, {24'h0, sc}, rd);
      wb(1'b1, ADDR_TSC, {29'h0, ps}, rd);
   endtask : cfg

   // High time and period of channel 0, from one rising edge to the next
   task automatic meas();
      int k;
      k = 0;
      while (chanPins.level[0] !== 1'b0 && k < 4000) begin @(posedge core_clk); k++; end
      while (chanPins.level[0] !== 1'b1 && k < 4000) begin @(posedge core_clk); k++; end
      hi = 0;
      per = 0;
      while (chanPins.level[0] === 1'b1 && per < 4000) begin @(posedge core_clk); hi++; per++; end
      while (chanPins.level[0] === 1'b0 && per < 4000) begin @(posedge core_clk); per++; end
      bail(k, 4000);
      bail(per, 4000);
   endtask : meas

   task automatic cnt_high();
      hi = 0;
      repeat (300) @(posedge core_clk);
      repeat (512) begin
         @(posedge core_clk);
         if (chanPins.level[0] === 1'b1) hi++;
      end
   endtask : cnt_high

   initial begin
      {errors, compares} = '0;
      {reset_n, wbCycI, wbStbI, wbWeI, waitMode, stopMode, breakActive} = '0;
      wbAdrI = 8'h00;
      wbSelI = 4'h0;
      wbDatI = 32'h0;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      wb(1'b0, ADDR_TSC, 32'h0, rd); chk("status reset", 32'h20, rd);
      wb(1'b0, ADDR_MODULO, 32'h0, rd); chk("modulo reset", 32'hffff, rd);
      wb(1'b0, 8'h1c, 32'h0, rd); chk("unmapped read", 32'h0, rd);
      cfg(8'h1a, 16'h80, 3'h0); meas();
      chk("period", 32'd256, per);
      chk("half duty", 32'd128, hi);
      chk("ch0 driven", 32'h0, 32'(chanPins.driveN[0]));
      cfg(8'h1a, 16'h40, 3'h0); meas(); chk("clear width", 32'd64, hi);
      cfg(8'h1e, 16'h40, 3'h0); meas(); chk("set width", 32'd192, hi);
      cfg(8'h1a, 16'h40, 3'h1); meas(); chk("div2 period", 32'd512, per);
      cfg(8'h18, 16'h40, 3'h0); cnt_high(); chk("zero duty", 32'd0, hi);
      cfg(8'h1b, 16'h40, 3'h0); cnt_high(); chk("full duty", 32'd512, hi);
      cfg(8'h1a, 16'h40, 3'h7); repeat (300) @(posedge core_clk);
      wb(1'b0, ADDR_COUNT, 32'h0, rd); chk("code 7 idle", 32'h0, rd);
      // Divide by 64 leaves room for many accesses between overflows
      cfg(8'h5a, 16'h40, 3'h6);
      wb(1'b0, ADDR_TSC, 32'h0, rd);
      wb(1'b1, ADDR_TSC, 32'h6, rd);
      wb(1'b0, ADDR_CH0_SC, 32'h0, rd);
      wb(1'b1, ADDR_CH0_SC, 32'h5a, rd);
      chk("ch irq cleared", 32'h0, 32'(irqOut.channel[0]));
      n = 0;
      while (irqOut.channel[0] !== 1'b1 && n < 6000) begin @(posedge core_clk); n++; end
      bail(n, 6000);
      n = 0;
      do begin
         wb(1'b0, ADDR_TSC, 32'h0, rd);
         n++;
      end while (rd[FLAG_BIT] !== 1'b1 && n < 8000);
      bail(n, 8000);
      chk("ovf irq masked", 32'h0, 32'(irqOut.overflow));
      wb(1'b1, ADDR_TSC, 32'hc6, rd);
      repeat (3) @(posedge core_clk);
      chk("ovf irq", 32'h1, 32'(irqOut.overflow));
      chk("wake", 32'h1, 32'(irqOut.wake));
      wb(1'b0, ADDR_TSC, 32'h0, rd);
      breakActive <= 1'b1;
      wb(1'b0, ADDR_COUNT, 32'h0, a);
      repeat (150) @(posedge core_clk);
      wb(1'b0, ADDR_COUNT, 32'h0, b); chk("break count", a, b);
      wb(1'b1, ADDR_TSC, 32'h46, rd);
      wb(1'b0, ADDR_TSC, 32'h0, rd); chk("break flag", 32'h1, 32'(rd[FLAG_BIT]));
      breakActive <= 1'b0;
      wb(1'b1, ADDR_TSC, 32'h46, rd);
      repeat (3) @(posedge core_clk);
      chk("ovf cleared", 32'h0, 32'(irqOut.overflow));
      stopMode <= 1'b1;
      wb(1'b0, ADDR_COUNT, 32'h0, a);
      repeat (200) @(posedge core_clk);
      wb(1'b0, ADDR_COUNT, 32'h0, b); chk("stop count", a, b);
      stopMode <= 1'b0;
      repeat (200) @(posedge core_clk);
      wb(1'b0, ADDR_COUNT, 32'h0, a); chk("count resumes", 32'h1, 32'(a != b));
      waitMode <= 1'b1;
      wb(1'b0, ADDR_TSC, 32'h0, rd); chk("wait read", 32'h0, rd);
      wb(1'b1, ADDR_MODULO, 32'h1234, rd);
      waitMode <= 1'b0;
      wb(1'b0, ADDR_MODULO, 32'h0, rd); chk("wait write", 32'hff, rd);
      cfg(8'h2a, 16'h40, 3'h0); meas(); chk("linked ch0", 32'd64, hi);
      wb(1'b1, ADDR_CH1_VAL, 32'hc0, rd); meas(); chk("ch1 takes", 32'd192, hi);
      wb(1'b1, ADDR_CH0_VAL, 32'h20, rd); meas(); chk("ch0 back", 32'd32, hi);
      chk("ch1 released", 32'h1, 32'(chanPins.driveN[1]));
      chk("ch1 gpio", 32'h1, 32'(pinWire[1]));
      wb(1'b1, ADDR_CH1_SC, 32'h5a, rd);
      wb(1'b0, ADDR_CH1_SC, 32'h0, rd); chk("ch1 control", 32'h0, rd);
      results();
   end
endmodule : test_tpw_timer

bind tpw_timer tpw_timer_monitor mon_u (.core_clk(core_clk), .reset_n(reset_n),
   .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
   .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .waitMode(waitMode),
   .stopMode(stopMode), .breakActive(breakActive), .breakClearEnable(breakClearEnable),
   .chanPinIn(chanPinIn), .chanPins(chanPins), .irqOut(irqOut));

// ---- testbench/tpw_pin_load.sv ----
// External load on the two channel pins.
// Assumes the bench supplies the general-purpose level of a released pin.
`timescale 1ns/1ps
module tpw_pin_load
   import tpw_pkg::*;
(
   input  wire logic [1:0] gpioLevel,
   input  wire tpw_pins_t  chanPins,
   output logic [1:0]      pinWire
);
   // A released pin follows the port's own level, never the timer's last value
   assign pinWire = (chanPins.level & ~chanPins.driveN) | (gpioLevel & chanPins.driveN);
endmodule : tpw_pin_load

// ---- testbench/tpw_timer_monitor.sv ----
// Port checker for the PWM timer: bus handshake, low-power holds, interrupt lines.
// Assumes it is bound to tpw_timer and sees nothing but that module's ports.
`timescale 1ns/1ps
module tpw_timer_monitor
   import tpw_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        wbCycI,
   input wire logic        wbStbI,
   input wire logic        wbWeI,
   input wire logic [7:0]  wbAdrI,
   input wire logic [3:0]  wbSelI,
   input wire logic [31:0] wbDatI,
   input wire logic [31:0] wbDatO,
   input wire logic        wbAckO,
   input wire logic        waitMode,
   input wire logic        stopMode,
   input wire logic        breakActive,
   input wire logic        breakClearEnable,
   input wire logic [1:0]  chanPinIn,
   input wire tpw_pins_t   chanPins,
   input wire tpw_irq_t    irqOut
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic req;
   assign req = wbCycI && wbStbI;

   chk_ack_answer:
      assert property (req && !wbAckO |=> wbAckO) else $error("ack not given");
   chk_ack_single:
      assert property (wbAckO |=> !wbAckO) else $error("ack longer than one cycle");
   chk_ack_cause:
      assert property ($rose(wbAckO) |-> $past(req)) else $error("ack without request");
   chk_data_idle:
      assert property (!wbAckO |-> wbDatO == 32'h0) else $error("read data outside ack");
   chk_wait_read:
      assert property ((waitMode && req && !wbAckO) ##1 waitMode |-> wbAckO && wbDatO == 32'h0)
      else $error("register visible in wait mode");
   // Two quiet cycles excluded after a bus write, which may move the pin on its own
   chk_stop_hold:
      assert property (stopMode && $past(stopMode) && $past(stopMode, 2) && !$past(wbAckO)
         && !$past(wbAckO, 2) |-> $stable(chanPins.level)) else $error("pin moved in stop");
   chk_break_hold:
      assert property (breakActive && $past(breakActive) && $past(breakActive, 2)
         && !$past(wbAckO) && !$past(wbAckO, 2) |-> $stable(chanPins.level))
      else $error("pin moved in break");
   chk_ovf_irq_hold:
      assert property ($fell(irqOut.overflow) |-> $past(wbAckO) || $past(wbAckO, 2))
      else $error("overflow request dropped without access");
   chk_ch_irq_hold:
      assert property ($fell(irqOut.channel[0]) |-> $past(wbAckO) || $past(wbAckO, 2))
      else $error("channel request dropped without access");
   chk_wake_src:
      assert property ($rose(irqOut.wake) |-> irqOut.overflow || (|irqOut.channel)
         || $past(irqOut.overflow || (|irqOut.channel))) else $error("wake without source");

   cover property (wbAckO && wbWeI);
   cover property ($rose(irqOut.overflow));
   cover property ($rose(chanPins.level[0]));
endmodule : tpw_timer_monitor

// ---- verilog/tpw_prescaler.sv ----
// Prescaler for the PWM timer counter: one-cycle tick at the selected rate.
// Assumes run and clear come from logic on the same core clock.
`timescale 1ns/1ps
module tpw_prescaler
   import tpw_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       run,
   input  wire logic       clear,
   input  wire logic [2:0] prescaleSelect,
   output logic            tick
);

   typedef struct packed {
      logic [5:0] div;
   } tpw_presc_state_t;

   tpw_presc_state_t state;
   tpw_presc_state_t next_state;
   logic [5:0]       mask;

   always_comb begin
      next_state = state;
      mask       = 6'((7'h01 << prescaleSelect) - 7'h01);
      tick       = run && (prescaleSelect != PS_OFF) && ((state.div & mask) == mask); // [RULE22]
      if (clear) begin
         next_state.div = 6'h00; // [RULE23]
      end else if (run) begin
         next_state.div = state.div + 6'h01;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule : tpw_prescaler

// ---- verilog/tpw_timer.sv ----
// Two-channel 16-bit PWM timer with capture, compare and buffered PWM.
// Assumes a classic Wishbone master and system mode levels on the core clock.
`timescale 1ns/1ps
module tpw_timer
   import tpw_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        wbCycI,
   input  wire logic        wbStbI,
   input  wire logic        wbWeI,
   input  wire logic [7:0]  wbAdrI,
   input  wire logic [3:0]  wbSelI,
   input  wire logic [31:0] wbDatI,
   output logic      [31:0] wbDatO,
   output logic             wbAckO,
   input  wire logic        waitMode,
   input  wire logic        stopMode,
   input  wire logic        breakActive,
   input  wire logic        breakClearEnable,
   input  wire logic [1:0]  chanPinIn,
   output tpw_pins_t        chanPins,
   output tpw_irq_t         irqOut
);

   tpw_state_t  state;
   tpw_state_t  next_state;
   logic        tick;
   logic        run;
   logic        prescClear;
   logic        access;
   logic        wrDo;
   logic        rdDo;
   logic        clrAllowed;
   logic        linked;
   logic        ovf;
   logic [15:0] nextCount;
   logic [1:0]  match;
   logic [1:0]  capture;
   logic [15:0] cmpVal;
   logic [1:0]  rise;
   logic [1:0]  fall;
   logic [1:0]  stable;
   logic [7:0]  scAddr [2];
   logic [7:0]  valAddr [2];

   assign scAddr[0]  = ADDR_CH0_SC;
   assign scAddr[1]  = ADDR_CH1_SC;
   assign valAddr[0] = ADDR_CH0_VAL;
   assign valAddr[1] = ADDR_CH1_VAL;

   // Byte lanes of a 16-bit field
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
      logic [15:0] res;
      res = old;
      if (sel[0]) begin
         res[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         res[15:8] = dat[15:8];
      end
      return res;
   endfunction : merge16

   // A channel drives its pin as output compare or PWM
   function automatic logic isOutput(input tpw_chsc_t c);
      return (c.modeB || c.modeA) && (c.edgeLevel != ELS_NONE);
   endfunction : isOutput

   function automatic logic isCapture(input tpw_chsc_t c);
      return !c.modeB && !c.modeA && (c.edgeLevel != ELS_NONE);
   endfunction : isCapture

   tpw_prescaler u_prescaler (
      .core_clk       (core_clk),
      .reset_n        (reset_n),
      .run            (run),
      .clear          (prescClear),
      .prescaleSelect (state.timer_status_control.prescaleSelect),
      .tick           (tick)
   );

   // Halted by the stop bit, by stop mode and by a break; wait mode keeps it running
   assign run = !state.timer_status_control.stop && !stopMode && !breakActive; // [RULE17] [RULE18] [RULE19]

   // Registers are closed to the CPU in wait mode; the bus still gets an answer
   assign access     = wbCycI && wbStbI && !waitMode; // [RULE17]
   assign wrDo       = access && state.ack && wbWeI;
   assign rdDo       = access && !state.ack && !wbWeI;
   assign clrAllowed = !breakActive || breakClearEnable; // [RULE20]
   assign prescClear = wrDo && (wbAdrI == ADDR_TSC) && wbSelI[0] && wbDatI[TRST_BIT];
   assign linked     = state.chsc[0].modeB;

   always_comb begin
      next_state          = state;
      next_state.timer_status_control.trst = 1'b0; // [RULE23]
      next_state.ack      = wbCycI && wbStbI && !state.ack;
      match               = 2'b00;
      capture             = 2'b00;
      cmpVal              = 16'h0000;

      // Pin synchronisers: a level counts once stages two and three agree
      for (int i = 0; i < 2; i++) begin
         next_state.pinSync[i] = {state.pinSync[i][1:0], chanPinIn[i]};
         stable[i]             = state.pinSync[i][1] == state.pinSync[i][2];
         rise[i]               = stable[i] && state.pinSync[i][2] && !state.pinSeen[i];
         fall[i]               = stable[i] && !state.pinSync[i][2] && state.pinSeen[i];
         if (stable[i]) begin
            next_state.pinSeen[i] = state.pinSync[i][2];
         end
      end

      // Counter: wraps to zero on the tick after reaching the modulo value
      ovf       = tick && (state.count == state.modulo); // [RULE15] [RULE24]
      nextCount = ovf ? COUNT_RESET : state.count + 16'h0001; // [RULE3] [RULE24]
      if (tick) begin
         next_state.count = nextCount;
      end

      // Buffered pair hands control to the last written registers at period start
      if (ovf && linked && state.pendSwap) begin
         next_state.activeSel = state.lastWritten; // [RULE6]
         next_state.pendSwap  = 1'b0;
      end

      for (int i = 0; i < 2; i++) begin
         if (i == 0 && linked && state.activeSel) begin
            cmpVal = state.value[1]; // [RULE5]
         end else begin
            cmpVal = state.value[i];
         end
         // Channel 1 is idle while linked
         if (i == 0 || !linked) begin // [RULE7] [RULE21]
            // Match as the counter steps onto the value: 0080 of 00ff gives 128 high ticks
            match[i]   = tick && isOutput(state.chsc[i]) && (nextCount == cmpVal); // [RULE2] [RULE4]
            capture[i] = isCapture(state.chsc[i]) && !state.timer_status_control.stop &&
                         (((state.chsc[i].edgeLevel == ELS_TOGGLE) && rise[i]) ||
                          ((state.chsc[i].edgeLevel == ELS_CLEAR) && fall[i]) ||
                          ((state.chsc[i].edgeLevel == ELS_SET) && (rise[i] || fall[i])));
            if (capture[i]) begin
               next_state.value[i] = state.count; // [RULE21]
            end
            if (isOutput(state.chsc[i])) begin
               if (ovf && state.chsc[i].toggleOnOverflow) begin
                  next_state.pins.level[i] = !state.pins.level[i]; // [RULE1] [RULE13]
               end
               // Compare wins over a coincident toggle, so a zero width stays at 0%
               if (match[i]) begin
                  case (state.chsc[i].edgeLevel)
                     ELS_TOGGLE: next_state.pins.level[i] = !state.pins.level[i];
                     ELS_CLEAR:  next_state.pins.level[i] = 1'b0; // [RULE11]
                     ELS_SET:    next_state.pins.level[i] = 1'b1; // [RULE11]
                     default:    next_state.pins.level[i] = state.pins.level[i];
                  endcase
               end
               if (state.chsc[i].maxDuty && state.chsc[i].toggleOnOverflow) begin
                  next_state.pins.level[i] = state.chsc[i].edgeLevel == ELS_CLEAR; // [RULE14]
               end
            end
         end
      end

      // Timer drives a pin only while that channel compares (drive enable is low)
      next_state.pins.driveN[0] = !isOutput(state.chsc[0]); // [RULE21]
      next_state.pins.driveN[1] = linked || !isOutput(state.chsc[1]); // [RULE7]

      // Read side: a read with a flag set arms its two-step clear
      if (rdDo) begin
         next_state.rdat = 32'h0000_0000;
         case (wbAdrI)
            ADDR_TSC: begin
               next_state.rdat[7:0] = state.timer_status_control;
               if (state.timer_status_control.flag && clrAllowed) begin
                  next_state.ovfArm = 1'b1; // [RULE25] [RULE20]
               end
            end
            ADDR_COUNT:   next_state.rdat[15:0] = state.count;
            ADDR_MODULO:  next_state.rdat[15:0] = state.modulo;
            ADDR_CH0_SC,
            ADDR_CH1_SC: begin
               for (int i = 0; i < 2; i++) begin
                  if (wbAdrI == scAddr[i]) begin
                     next_state.rdat[7:0] = state.chsc[i];
                     if (state.chsc[i].flag && clrAllowed) begin
                        next_state.chArm[i] = 1'b1; // [RULE25] [RULE20]
                     end
                  end
               end
            end
            ADDR_CH0_VAL: next_state.rdat[15:0] = state.value[0];
            ADDR_CH1_VAL: next_state.rdat[15:0] = state.value[1];
            default:      next_state.rdat = 32'h0000_0000;
         endcase
      end else begin
         next_state.rdat = 32'h0000_0000; // Data stands only in the ack cycle
      end

      // Write side: takes effect on the edge where the master sees the answer
      if (wrDo) begin
         case (wbAdrI)
            ADDR_TSC: begin
               if (wbSelI[0]) begin
                  next_state.timer_status_control.irqEnable      = wbDatI[6];
                  next_state.timer_status_control.stop           = wbDatI[5];
                  next_state.timer_status_control.prescaleSelect = wbDatI[2:0]; // [RULE22]
                  if (wbDatI[TRST_BIT]) begin
                     next_state.count = COUNT_RESET; // [RULE23]
                  end
                  if (clrAllowed) begin
                     if (state.ovfArm && !wbDatI[FLAG_BIT]) begin
                        next_state.timer_status_control.flag = 1'b0; // [RULE25]
                     end
                     next_state.ovfArm = 1'b0;
                  end
               end
            end
            ADDR_MODULO: next_state.modulo = merge16(state.modulo, wbDatI, wbSelI);
            ADDR_CH0_SC,
            ADDR_CH1_SC: begin
               for (int i = 0; i < 2; i++) begin
                  // Channel 1 control is ignored while linked
                  if (wbAdrI == scAddr[i] && wbSelI[0] && (i == 0 || !linked)) begin // [RULE7]
                     next_state.chsc[i].irqEnable        = wbDatI[6];
                     next_state.chsc[i].modeB            = (i == 0) ? wbDatI[5] : 1'b0; // [RULE21]
                     next_state.chsc[i].modeA            = wbDatI[4];
                     next_state.chsc[i].edgeLevel        = wbDatI[3:2];
                     next_state.chsc[i].toggleOnOverflow = wbDatI[1];
                     next_state.chsc[i].maxDuty          = wbDatI[0];
                     // With no edge/level action, mode A presets the idle level (1 = low)
                     if (wbDatI[3:2] == ELS_NONE) begin
                        next_state.pins.level[i] = !wbDatI[4];
                     end
                     if (clrAllowed) begin
                        if (state.chArm[i] && !wbDatI[FLAG_BIT]) begin
                           next_state.chsc[i].flag = 1'b0; // [RULE25]
                        end
                        next_state.chArm[i] = 1'b0;
                     end
                  end
               end
               if (wbAdrI == ADDR_CH0_SC && wbSelI[0] && !wbDatI[5]) begin
                  next_state.activeSel = 1'b0;
                  next_state.pendSwap  = 1'b0;
               end
            end
            ADDR_CH0_VAL,
            ADDR_CH1_VAL: begin
               for (int i = 0; i < 2; i++) begin
                  if (wbAdrI == valAddr[i]) begin
                     next_state.value[i] = merge16(state.value[i], wbDatI, wbSelI);
                     // Writing the active pair simply acts unbuffered
                     if (linked) begin
                        next_state.lastWritten = (i == 1); // [RULE6] [RULE8]
                        next_state.pendSwap    = 1'b1;
                     end
                  end
               end
            end
            default: next_state.rdat = state.rdat;
         endcase
      end

      // Events set flags after any clear, so a coincident event is never lost
      if (ovf) begin
         next_state.timer_status_control.flag = 1'b1; // [RULE15] [RULE25]
      end
      for (int i = 0; i < 2; i++) begin
         if (match[i] || capture[i]) begin
            next_state.chsc[i].flag = 1'b1; // [RULE16] [RULE25]
         end
      end

      // Request lines follow flag and enable until the flag is cleared
      next_state.irq.overflow   = next_state.timer_status_control.flag && next_state.timer_status_control.irqEnable; // [RULE15] [RULE26]
      next_state.irq.channel[0] = next_state.chsc[0].flag &&
                                  next_state.chsc[0].irqEnable; // [RULE16] [RULE26]
      next_state.irq.channel[1] = next_state.chsc[1].flag &&
                                  next_state.chsc[1].irqEnable && !linked; // [RULE9] [RULE26]
      next_state.irq.wake       = next_state.irq.overflow ||
                                  (|next_state.irq.channel); // [RULE17]
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state        <= '0;
         state.timer_status_control    <= TSC_RESET;
         state.modulo <= MODULO_RESET;
         state.pins   <= '{level: 2'b00, driveN: 2'b11};
      end else begin
         state <= next_state;
      end
   end

   assign wbDatO   = state.rdat;
   assign wbAckO   = state.ack;
   assign chanPins = state.pins;
   assign irqOut   = state.irq;

endmodule : tpw_timer
